// file: rtl/lac_core.sv
// Latch acknowledge controller: latches for LEDs, relays, SCADA and trips.
// Assumes all inputs synchronous to core_clk_in and an Avalon-MM master.
//
// Chosen here: the register addresses and the Avalon-MM register port.
`default_nettype none
module lac_core (
   input  wire logic                          core_clk_in,
   input  wire logic                          reset_in,
   input  wire logic                          ce_in,
   input  wire logic [lac_pkg::AW-1:0]        avs_address_in,
   input  wire logic                          avs_read_in,
   input  wire logic                          avs_write_in,
   input  wire logic [lac_pkg::DW-1:0]        avs_writedata_in,
   input  wire logic [3:0]                    avs_byteenable_in,
   output logic      [lac_pkg::DW-1:0]        avs_readdata_out,
   output logic                               avs_waitrequest_out,
   input  wire logic [lac_pkg::N_LED-1:0]     led_src_in,
   input  wire logic [lac_pkg::N_BO-1:0]      bo_src_in,
   input  wire logic [lac_pkg::N_SCADA-1:0]   scada_src_in,
   input  wire logic [lac_pkg::N_SG-1:0]      trip_src_in,
   input  wire logic [lac_pkg::N_LED-1:0]     led_ack_src_in,
   input  wire logic [lac_pkg::N_BO-1:0]      bo_ack_src_in,
   input  wire logic [lac_pkg::N_SCADA-1:0]   scada_ack_src_in,
   input  wire logic [lac_pkg::N_SG-1:0]      trip_ack_source_in,
   input  wire logic                          led_group_ack_in,
   input  wire logic                          bo_group_ack_in,
   input  wire logic                          scada_group_ack_in,
   input  wire logic                          prot_alarm_in,
   input  wire logic                          prot_new_alarm_in,
   input  wire logic                          panel_key_in,
   output logic      [lac_pkg::N_LED-1:0]     led_out,
   output logic      [lac_pkg::N_BO-1:0]      bo_out,
   output logic      [lac_pkg::N_SCADA-1:0]   scada_out,
   output logic      [lac_pkg::N_SG-1:0]      trip_out,
   output logic                               irq_out
);
   localparam int unsigned N   = lac_pkg::N_OBJ;
   localparam int unsigned NL  = lac_pkg::N_LED;
   localparam int unsigned CW  = lac_pkg::CTRL_W;
   localparam int unsigned IW  = lac_pkg::IRQ_W;
   localparam int unsigned DLW = lac_pkg::DLY_W;

   logic                     wrq_q;
   logic [lac_pkg::DW-1:0]   rdata_q;
   logic [CW-1:0]            ctrl_q;
   logic [N-1:0]             latch_en_q;
   logic [NL-1:0]            auto_q;
   logic [DLW-1:0]           dly_q;
   logic [IW-1:0]            irq_sts_q;
   logic [IW-1:0]            irq_en_q;
   logic                     irq_q;
   logic [N-1:0]             held_q;
   logic [N-1:0]             pend_q;
   logic [N-1:0]             out_q;
   logic [lac_pkg::EV_W-1:0] prev_q;

   // ==========================================================
   // Bus decode
   logic                   bus_req;
   logic                   wr_acc;
   logic [lac_pkg::DW-1:0] wmask;
   logic [lac_pkg::DW-1:0] rd_mux;
   logic sel_ctrl, sel_latch, sel_auto, sel_cmd, sel_state;
   logic sel_dly, sel_ists, sel_iclr, sel_ien;

   assign bus_req   = avs_read_in | avs_write_in;
   assign wr_acc    = avs_write_in & ~wrq_q;
   assign wmask     = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                       {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   assign sel_ctrl  = avs_address_in == lac_pkg::ADDR_CTRL;
   assign sel_latch = avs_address_in == lac_pkg::ADDR_LATCH_EN;
   assign sel_auto  = avs_address_in == lac_pkg::ADDR_AUTO;
   assign sel_cmd   = avs_address_in == lac_pkg::ADDR_CMD;
   assign sel_state = avs_address_in == lac_pkg::ADDR_STATE;
   assign sel_dly   = avs_address_in == lac_pkg::ADDR_OFF_DLY;
   assign sel_ists  = avs_address_in == lac_pkg::ADDR_IRQ_STS;
   assign sel_iclr  = avs_address_in == lac_pkg::ADDR_IRQ_CLR;
   assign sel_ien   = avs_address_in == lac_pkg::ADDR_IRQ_EN;

   // Write-only and unmapped words read as zero
   assign rd_mux = sel_ctrl  ? {{(32-CW){1'b0}}, ctrl_q} :
                   sel_latch ? {{(32-N){1'b0}}, latch_en_q} :
                   sel_auto  ? {{(32-NL){1'b0}}, auto_q} :
                   sel_state ? {{(32-N){1'b0}}, held_q} :
                   sel_dly   ? {{(32-DLW){1'b0}}, dly_q} :
                   sel_ists  ? {{(32-IW){1'b0}}, irq_sts_q} :
                   sel_ien   ? {{(32-IW){1'b0}}, irq_en_q} : 32'h00000000;

   // Byte-lane merge of write data into the old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                         input logic [31:0] wd);
      merge = (old & ~m) | (wd & m);
   endfunction

   logic [31:0] ctrl_m, latch_m, auto_m, dly_m, ien_m, wd_m;
   assign ctrl_m  = merge({{(32-CW){1'b0}}, ctrl_q}, wmask, avs_writedata_in);
   assign latch_m = merge({{(32-N){1'b0}}, latch_en_q}, wmask, avs_writedata_in);
   assign auto_m  = merge({{(32-NL){1'b0}}, auto_q}, wmask, avs_writedata_in);
   assign dly_m   = merge({{(32-DLW){1'b0}}, dly_q}, wmask, avs_writedata_in);
   assign ien_m   = merge({{(32-IW){1'b0}}, irq_en_q}, wmask, avs_writedata_in);
   assign wd_m    = avs_writedata_in & wmask;

   // Answer one cycle after the request is seen, then rearm
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         wrq_q   <= 1'b1;
         rdata_q <= '0;
      end else if (ce_in) begin
         wrq_q <= ~(bus_req & wrq_q);
         if (bus_req & wrq_q) begin
            rdata_q <= rd_mux;
         end
      end
   end
   assign avs_waitrequest_out = wrq_q;
   assign avs_readdata_out    = rdata_q;

   // ==========================================================
   // Configuration registers
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         ctrl_q     <= lac_pkg::CTRL_RST;
         latch_en_q <= lac_pkg::LATCH_RST;
         auto_q     <= lac_pkg::AUTO_RST;
         dly_q      <= lac_pkg::DLY_RST;
         irq_en_q   <= '0;
      end else if (ce_in && wr_acc) begin
         if (sel_ctrl)  ctrl_q     <= ctrl_m[CW-1:0];
         if (sel_latch) latch_en_q <= latch_m[N-1:0];
         if (sel_auto)  auto_q     <= auto_m[NL-1:0];
         if (sel_dly)   dly_q      <= dly_m[DLW-1:0];
         if (sel_ien)   irq_en_q   <= ien_m[IW-1:0];
      end
   end

   // ==========================================================
   // Acknowledge sources
   logic [lac_pkg::EV_W-1:0]      ack_lvl, rise;
   logic [lac_pkg::CLS_W-1:0]     grp_cls, cmd_cls, key_cls;
   logic [N-1:0] src_all, ind_rise, remote_req, ack_req, auto_req;
   logic         remote, alarm_evt, key_rise, blocked_evt;

   assign src_all  = {trip_src_in, scada_src_in, bo_src_in, led_src_in};
   assign ack_lvl  = {panel_key_in, prot_new_alarm_in, prot_alarm_in, scada_group_ack_in,
                      bo_group_ack_in, led_group_ack_in, trip_ack_source_in,
                      scada_ack_src_in, bo_ack_src_in, led_ack_src_in};
   assign rise      = ack_lvl & ~prev_q;
   assign ind_rise  = rise[N-1:0];
   assign alarm_evt = rise[lac_pkg::EV_ALARM] | rise[lac_pkg::EV_NEW];
   assign key_rise  = rise[lac_pkg::EV_KEY];
   assign remote    = ctrl_q[lac_pkg::CTRL_REMOTE];
   // Trip commands have no group input, hence the zero class bit
   assign grp_cls   = {1'b0, rise[lac_pkg::EV_GRP_LO +: lac_pkg::EV_GRP_W]};
   assign cmd_cls   = (wr_acc & sel_cmd) ? wd_m[lac_pkg::CLS_W-1:0] : '0;
   assign key_cls   = key_rise ? ctrl_q[lac_pkg::CTRL_KEY_LO +: lac_pkg::CLS_W] : '0;
   assign auto_req  = {{(N-NL){1'b0}}, auto_q & {NL{alarm_evt}}};
   assign remote_req = ind_rise | auto_req | lac_pkg::cls_expand(grp_cls | cmd_cls);
   assign ack_req    = (remote_req & {N{remote}}) | lac_pkg::cls_expand(key_cls);
   assign blocked_evt = ~remote & (|remote_req);

   // ==========================================================
   // Per-object latches
   logic [lac_pkg::N_BO-1:0] bo_exp;
   logic [N-1:0]             exp_all, set_w, rel_w, held_d, pend_d;

   assign exp_all = {{(N-lac_pkg::BO_LO-lac_pkg::N_BO){1'b1}}, bo_exp, {NL{1'b1}}};

   for (genvar b = 0; b < lac_pkg::N_BO; b++) begin : g_bo
      lac_off_delay u_dly (
         .core_clk_in (core_clk_in),
         .reset_in    (reset_in),
         .ce_in       (ce_in),
         .src_in      (bo_src_in[b]),
         .delay_in    (dly_q),
         .expired_out (bo_exp[b])
      );
   end

   // A relay acknowledged during its off-delay stays pending until expiry
   for (genvar i = 0; i < N; i++) begin : g_obj
      assign set_w[i]  = src_all[i] & latch_en_q[i];
      assign rel_w[i]  = (ack_req[i] | pend_q[i]) & ~src_all[i] & exp_all[i];
      assign held_d[i] = latch_en_q[i] & (set_w[i] | (held_q[i] & ~rel_w[i]));
      assign pend_d[i] = held_q[i] & ~src_all[i] & ~rel_w[i] & (pend_q[i] | ack_req[i]);
   end

   // ==========================================================
   // Interrupts: set wins over a clear in the same cycle
   logic [IW-1:0] evt, iclr, irq_sts_d;
   assign evt       = {blocked_evt, |(held_q & ~held_d), |(held_d & ~held_q)};
   assign iclr      = (wr_acc & sel_iclr) ? wd_m[IW-1:0] : '0;
   assign irq_sts_d = (irq_sts_q & ~iclr) | evt;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         held_q    <= '0;
         pend_q    <= '0;
         out_q     <= '0;
         prev_q    <= '0;
         irq_sts_q <= '0;
         irq_q     <= 1'b0;
      end else if (ce_in) begin
         held_q    <= held_d;
         pend_q    <= pend_d;
         out_q     <= src_all | held_d | ~exp_all;
         prev_q    <= ack_lvl;
         irq_sts_q <= irq_sts_d;
         irq_q     <= |(irq_sts_d & irq_en_q);
      end
   end

   assign led_out   = out_q[NL-1:0];
   assign bo_out    = out_q[lac_pkg::BO_LO +: lac_pkg::N_BO];
   assign scada_out = out_q[lac_pkg::BO_LO + lac_pkg::N_BO +: lac_pkg::N_SCADA];
   assign trip_out  = out_q[N-1 -: lac_pkg::N_SG];
   assign irq_out   = irq_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);

   a_bus_answer: assert property (ce_in && bus_req && wrq_q |=> !wrq_q)
      else $error("bus request not answered");
   a_clear_src_low: assert property (ce_in |=>
      ($past(held_q) & ~held_q & $past(src_all)) == '0)
      else $error("latch cleared while its source was active");
   a_clear_has_cause: assert property (ce_in |=>
      ($past(held_q) & ~held_q & ~$past(ack_req | pend_q) & $past(latch_en_q)) == '0)
      else $error("latch cleared without acknowledge");
   a_remote_blocked: assert property (ce_in && !remote && !key_rise |=>
      (($past(held_q) & ~held_q & $past(latch_en_q & ~pend_q)) == '0))
      else $error("remote acknowledge acted while disabled");
   a_auto_led_only: assert property (ce_in && alarm_evt && !key_rise &&
      (ind_rise | lac_pkg::cls_expand(grp_cls | cmd_cls)) == '0 |=>
      (($past(held_q[N-1:NL]) & ~held_q[N-1:NL]) & ~$past(pend_q[N-1:NL])) == '0)
      else $error("alarm cleared a non-LED latch");
   a_auto_clears: assert property (ce_in && remote && alarm_evt |=>
      (held_q[NL-1:0] & $past(auto_q & ~led_src_in)) == '0)
      else $error("auto acknowledge missed an LED");
   a_led_group: assert property (ce_in && remote && rise[lac_pkg::EV_GRP_LO] |=>
      (held_q[NL-1:0] & ~$past(led_src_in)) == '0)
      else $error("LED group acknowledge incomplete");
   a_trip_single: assert property (ce_in && remote |=>
      (held_q[N-1 -: lac_pkg::N_SG] & $past(ind_rise[N-1 -: lac_pkg::N_SG] & ~trip_src_in))
      == '0)
      else $error("trip acknowledge missed");
   a_key_clears: assert property (ce_in && key_rise |=>
      (held_q & $past(pend_q & ~src_all & exp_all)) == '0 &&
      (held_q & $past(lac_pkg::cls_expand(key_cls) & ~src_all & exp_all)) == '0)
      else $error("panel key acknowledge incomplete");
   a_cmd_clears: assert property (ce_in && remote && cmd_cls != '0 |=>
      (held_q & $past(lac_pkg::cls_expand(cmd_cls) & ~src_all & exp_all)) == '0)
      else $error("collective command incomplete");
   a_relay_delay: assert property (ce_in |=>
      ($past(held_q[lac_pkg::BO_LO +: lac_pkg::N_BO]) & ~held_q[lac_pkg::BO_LO +: lac_pkg::N_BO]
       & ~$past(bo_exp) & $past(latch_en_q[lac_pkg::BO_LO +: lac_pkg::N_BO])) == '0)
      else $error("relay released before off-delay expiry");
   a_irq_level: assert property (ce_in |=> irq_q == |(irq_sts_q & irq_en_q))
      else $error("interrupt output mismatch");

   c_auto: cover property (ce_in && remote && alarm_evt && |(held_q[NL-1:0] & auto_q));
   c_key: cover property (ce_in && key_rise && |held_q);
   c_pend: cover property (ce_in && |(pend_d & ~pend_q));
   c_block: cover property (ce_in && blocked_evt);
endmodule
`default_nettype wire

// file: rtl/lac_off_delay.sv
// Off-delay timer for one binary output relay.
// Assumes the delay value is in clock cycles and changes only rarely.
`default_nettype none
module lac_off_delay (
   input  wire logic                       core_clk_in,
   input  wire logic                       reset_in,
   input  wire logic                       ce_in,
   input  wire logic                       src_in,
   input  wire logic [lac_pkg::DLY_W-1:0]  delay_in,
   output logic                            expired_out
);
   logic [lac_pkg::DLY_W-1:0] cnt_q;
   logic [lac_pkg::DLY_W-1:0] cnt_d;
   logic                      exp_q;

   // ==========================================================
   // Reload while the source is on, count down after it drops
   assign cnt_d = src_in ? delay_in :
                  (cnt_q != '0) ? cnt_q - 16'h0001 : cnt_q;
   assign expired_out = exp_q;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cnt_q <= '0;
         exp_q <= 1'b1;
      end else if (ce_in) begin
         cnt_q <= cnt_d;
         exp_q <= ~src_in & (cnt_d == '0);
      end
   end

   // ==========================================================
   // Checks
   a_delay_reload: assert property (@(posedge core_clk_in) disable iff (reset_in)
      ce_in && src_in |=> !exp_q && cnt_q == $past(delay_in))
      else $error("off-delay did not reload");
   a_delay_expiry: assert property (@(posedge core_clk_in) disable iff (reset_in)
      ce_in && !src_in && cnt_q == 16'h0001 |=> exp_q)
      else $error("off-delay did not expire");
endmodule
`default_nettype wire

// file: rtl/lac_pkg.sv
// Constants, register map and helpers of the latch acknowledge controller.
// Assumes a 32-bit Avalon-MM register bus and byte addressing.
`default_nettype none
package lac_pkg;
   // ==========================================================
   // Object counts and layout of the object vector
   localparam int unsigned N_LED   = 8;
   localparam int unsigned N_BO    = 8;
   localparam int unsigned N_SCADA = 8;
   localparam int unsigned N_SG    = 4;
   localparam int unsigned N_OBJ   = N_LED + N_BO + N_SCADA + N_SG;
   localparam int unsigned BO_LO   = N_LED;
   localparam int unsigned DW      = 32;
   localparam int unsigned AW      = 8;
   localparam int unsigned DLY_W   = 16;

   // ==========================================================
   // Register offsets
   localparam logic [AW-1:0] ADDR_CTRL     = 8'h00;
   localparam logic [AW-1:0] ADDR_LATCH_EN = 8'h04;
   localparam logic [AW-1:0] ADDR_AUTO     = 8'h08;
   localparam logic [AW-1:0] ADDR_CMD      = 8'h0c;
   localparam logic [AW-1:0] ADDR_STATE    = 8'h10;
   localparam logic [AW-1:0] ADDR_OFF_DLY  = 8'h14;
   localparam logic [AW-1:0] ADDR_IRQ_STS  = 8'h18;
   localparam logic [AW-1:0] ADDR_IRQ_CLR  = 8'h1c;
   localparam logic [AW-1:0] ADDR_IRQ_EN   = 8'h20;

   // ==========================================================
   // Fields: class bits are led, relay, scada, trip from bit 0 up
   localparam int unsigned CLS_W       = 4;
   localparam int unsigned CTRL_REMOTE = 0;
   localparam int unsigned CTRL_KEY_LO = 1;
   localparam int unsigned CTRL_W      = CTRL_KEY_LO + CLS_W;
   localparam int unsigned IRQ_SET     = 0;
   localparam int unsigned IRQ_CLEAR   = 1;
   localparam int unsigned IRQ_BLOCK   = 2;
   localparam int unsigned IRQ_W       = 3;

   // Edge vector: individual sources, groups, alarms, panel key
   localparam int unsigned EV_GRP_LO = N_OBJ;
   localparam int unsigned EV_GRP_W  = 3;
   localparam int unsigned EV_ALARM  = N_OBJ + EV_GRP_W;
   localparam int unsigned EV_NEW    = EV_ALARM + 1;
   localparam int unsigned EV_KEY    = EV_NEW + 1;
   localparam int unsigned EV_W      = EV_KEY + 1;

   // ==========================================================
   // Reset values: remote enabled, rising edge of the panel key clears LEDs
   localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h03;
   localparam logic [N_OBJ-1:0]  LATCH_RST = 28'h0000000;
   localparam logic [N_LED-1:0]  AUTO_RST  = 8'h00;
   localparam logic [DLY_W-1:0]  DLY_RST   = 16'h0064;

   function automatic logic [N_OBJ-1:0] cls_expand(input logic [CLS_W-1:0] c);
      cls_expand = {{N_SG{c[3]}}, {N_SCADA{c[2]}}, {N_BO{c[1]}}, {N_LED{c[0]}}};
   endfunction
endpackage
`default_nettype wire

// file: sim/lac_field_model.sv
// Far side model: protection sources, acknowledge inputs, alarms, panel key.
// Assumes the bench calls its tasks; all lines change right after a rising edge.
`default_nettype none
module lac_field_model (
   input  wire logic        core_clk_in,
   output logic      [27:0] src_out,
   output logic      [27:0] ack_out,
   output logic      [5:0]  ev_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // State: ev is led grp, bo grp, scada grp, alarm, new alarm, key
   logic [27:0] src_q = '0;
   logic [27:0] ack_q = '0;
   logic [5:0]  ev_q  = '0;
   assign src_out = src_q;
   assign ack_out = ack_q;
   assign ev_out  = ev_q;
   task automatic put_src(input logic [27:0] v);
      @(posedge core_clk_in);
      src_q <= v;
   endtask
   // One high cycle, then low: a clean rising edge per call
   task automatic pulse(input logic [27:0] a, input logic [5:0] e);
      @(posedge core_clk_in);
      ack_q <= a;
      ev_q  <= e;
      @(posedge core_clk_in);
      ack_q <= '0;
      ev_q  <= '0;
   endtask
endmodule
`default_nettype wire

// file: sim/latch_acknowledge_control_bench.sv
// Self-checking bench of the latch acknowledge controller.
// Assumes lac_pkg, lac_core and lac_field_model are compiled first.
`default_nettype none
module latch_acknowledge_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Clock, reset, bus and design
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        rd_q = 1'b0;
   logic        wr_q = 1'b0;
   logic        ce   = 1'b1;
   logic [3:0]  be   = 4'hf;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic        wait_out;
   logic [27:0] src, ack;
   logic [5:0]  ev;
   logic [7:0]  led, bo, scd;
   logic [3:0]  trip;
   logic        irq;
   logic [31:0] q;
   int          failures = 0;
   int          n_checks = 0;
   logic [27:0] masks [5] = '{28'h00000ff, 28'h000ff00, 28'h0ff0000, 28'hf000000, 28'hfffffff};
   always #5 clk = ~clk;
   lac_field_model fld (.core_clk_in(clk), .src_out(src), .ack_out(ack), .ev_out(ev));
   lac_core dut (
      .core_clk_in(clk), .reset_in(rst), .ce_in(ce),
      .avs_address_in(adr), .avs_read_in(rd_q), .avs_write_in(wr_q),
      .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_out),
      .led_src_in(src[7:0]), .bo_src_in(src[15:8]), .scada_src_in(src[23:16]),
      .trip_src_in(src[27:24]), .led_ack_src_in(ack[7:0]), .bo_ack_src_in(ack[15:8]),
      .scada_ack_src_in(ack[23:16]), .trip_ack_source_in(ack[27:24]),
      .led_group_ack_in(ev[0]), .bo_group_ack_in(ev[1]), .scada_group_ack_in(ev[2]),
      .prot_alarm_in(ev[3]), .prot_new_alarm_in(ev[4]), .panel_key_in(ev[5]),
      .led_out(led), .bo_out(bo), .scada_out(scd), .trip_out(trip), .irq_out(irq));
   // ==========================================================
   // Tasks
   task automatic report_and_stop();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; no fixed latency assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      rd_q <= !w;
      wr_q <= w;
      adr  <= a;
      wd   <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wait_out !== 1'b0 && n < 200);
      q = rdata;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      if (n >= 200) begin
         failures++;
         report_and_stop();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic latch_all();
      fld.put_src(28'hfffffff);
      idle(2);
      fld.put_src(28'h0);
      idle(8);
   endtask
   // ==========================================================
   // Tests
   initial begin
      #200000;
      failures++;
      report_and_stop();
   end
   initial begin
      idle(3);
      rst <= 1'b0;
      rd(lac_pkg::ADDR_CTRL, 32'h3);
      rd(lac_pkg::ADDR_OFF_DLY, 32'h64);
      rd(lac_pkg::ADDR_LATCH_EN, 32'h0);
      rd(lac_pkg::ADDR_CMD, 32'h0);
      rd(8'h40, 32'h0);
      // Only lane 1 written: the low byte of the delay keeps its reset value
      be <= 4'h2;
      bus(1'b1, lac_pkg::ADDR_OFF_DLY, 32'h0000ab00);
      be <= 4'hf;
      rd(lac_pkg::ADDR_OFF_DLY, 32'hab64);
      bus(1'b1, lac_pkg::ADDR_LATCH_EN, 32'h0fffffff);
      bus(1'b1, lac_pkg::ADDR_OFF_DLY, 32'h3);
      bus(1'b1, lac_pkg::ADDR_AUTO, 32'h0f);
      bus(1'b1, lac_pkg::ADDR_IRQ_EN, 32'h7);
      latch_all();
      rd(lac_pkg::ADDR_STATE, 32'h0fffffff);
      chk({led, scd, trip}, 20'hffff_f);
      fld.put_src(28'hfffffff);
      fld.pulse(28'h1, 6'h0);
      fld.put_src(28'h0);
      idle(8);
      rd(lac_pkg::ADDR_STATE, 32'h0fffffff);
      fld.pulse(28'h1000102, 6'h0);
      idle(8);
      rd(lac_pkg::ADDR_STATE, 32'h0efffefd);
      chk({28'h0, trip}, 32'he);
      fld.pulse(28'h0, 6'h08);
      idle(4);
      rd(lac_pkg::ADDR_STATE, 32'h0efffef0);
      fld.pulse(28'h0, 6'h05);
      idle(4);
      rd(lac_pkg::ADDR_STATE, 32'h0e00fe00);
      // Remote off: group ignored, key set to relays still acts
      bus(1'b1, lac_pkg::ADDR_CTRL, 32'h04);
      fld.pulse(28'h0, 6'h02);
      idle(4);
      rd(lac_pkg::ADDR_STATE, 32'h0e00fe00);
      rd(lac_pkg::ADDR_IRQ_STS, 32'h7);
      chk({31'h0, irq}, 32'h1);
      fld.pulse(28'h0, 6'h20);
      idle(8);
      rd(lac_pkg::ADDR_STATE, 32'h0e000000);
      bus(1'b1, lac_pkg::ADDR_CTRL, 32'h03);
      // Ack right after the source falls: relay holds for the off-delay
      fld.put_src(28'h100);
      idle(3);
      fld.put_src(28'h0);
      fld.pulse(28'h100, 6'h0);
      chk({24'h0, bo}, 32'h1);
      // Latch still held while the off-delay runs, released only at expiry
      rd(lac_pkg::ADDR_STATE, 32'h0e000100);
      idle(10);
      chk({24'h0, bo}, 32'h0);
      bus(1'b1, lac_pkg::ADDR_IRQ_CLR, 32'h7);
      rd(lac_pkg::ADDR_IRQ_STS, 32'h0);
      bus(1'b1, lac_pkg::ADDR_IRQ_EN, 32'h0);
      latch_all();
      chk({31'h0, irq}, 32'h0);
      rd(lac_pkg::ADDR_IRQ_STS, 32'h1);
      for (int i = 0; i < 5; i++) begin
         latch_all();
         bus(1'b1, lac_pkg::ADDR_CMD, (i < 4) ? (32'h1 << i) : 32'hf);
         idle(8);
         rd(lac_pkg::ADDR_STATE, {4'h0, 28'hfffffff & ~masks[i]});
      end
      // Clock enable low: a source pulse must leave no latch behind
      ce <= 1'b0;
      fld.put_src(28'h1);
      idle(3);
      fld.put_src(28'h0);
      idle(1);
      ce <= 1'b1;
      rd(lac_pkg::ADDR_STATE, 32'h0);
      chk({24'h0, led}, 32'h0);
      // New alarm input alone clears the auto LEDs
      latch_all();
      fld.pulse(28'h0, 6'h10);
      idle(4);
      rd(lac_pkg::ADDR_STATE, 32'h0ffffff0);
      report_and_stop();
   end
endmodule
`default_nettype wire
